/* logic/csfm_pkg.sv */
package csfm_pkg;

	// ----------------------------------------------------------------
	// register map (byte addresses, one 32-bit word each)
	// ----------------------------------------------------------------
	localparam int ADDR_W = 4;
	localparam logic [ADDR_W-1:0] OFS_OSC_CTRL = 4'h0;
	localparam logic [ADDR_W-1:0] OFS_PLL_MULT = 4'h4;
	localparam logic [ADDR_W-1:0] OFS_RC_TRIM = 4'h8;
	localparam logic [ADDR_W-1:0] OFS_UNLOCK = 4'hC;

	// ----------------------------------------------------------------
	// oscillator control fields
	// ----------------------------------------------------------------
	localparam int POS_ACTIVE = 12;
	localparam int POS_REQ = 8;
	localparam int POS_LOCK = 5;
	localparam int POS_FAIL = 3;
	localparam int POS_SEC_EN = 1;
	localparam int POS_SWREQ = 0;

	// ----------------------------------------------------------------
	// reset values and widths
	// ----------------------------------------------------------------
	localparam int PLL_W = 9;
	localparam int TRIM_W = 6;
	localparam logic [PLL_W-1:0] RST_PLL_MULT = 9'h030;
	localparam logic [TRIM_W-1:0] RST_RC_TRIM = 6'h00;
	// unlock keys: values are arbitrary
	localparam logic [15:0] UNLOCK_KEY1 = 16'h5A5A;
	localparam logic [15:0] UNLOCK_KEY2 = 16'hA5A5;
	localparam int NEW_CLK_CYCLES = 10;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ----------------------------------------------------------------
	// clock sources
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		SRC_FRC = 3'h0,
		SRC_FRC_PLL = 3'h1,
		SRC_PRI = 3'h2,
		SRC_PRI_PLL = 3'h3,
		SRC_SEC = 3'h4,
		SRC_SLOW = 3'h5,
		SRC_FRC_DIV16 = 3'h6,
		SRC_FRC_DIVN = 3'h7
	} csfm_src_e;

	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_CHECK = 3'h1,
		ST_WAIT = 3'h3,
		ST_COUNT = 3'h2,
		ST_SWAP = 3'h6
	} csfm_state_e;

	function automatic logic uses_frc(input logic [2:0] s);
		uses_frc = (s == SRC_FRC) || (s == SRC_FRC_PLL) ||
			(s == SRC_FRC_DIV16) || (s == SRC_FRC_DIVN);
	endfunction : uses_frc

	function automatic logic uses_pri(input logic [2:0] s);
		uses_pri = (s == SRC_PRI) || (s == SRC_PRI_PLL);
	endfunction : uses_pri

	function automatic logic uses_pll(input logic [2:0] s);
		uses_pll = (s == SRC_FRC_PLL) || (s == SRC_PRI_PLL);
	endfunction : uses_pll

endpackage : csfm_pkg

/* logic/csfm_cnt_if.sv */
`timescale 1ns/1ps
interface csfm_cnt_if;
	logic start;
	logic done;
	logic new_low;
	modport master (output start, input done, input new_low);
	modport counter (input start, output done, output new_low);
endinterface : csfm_cnt_if

/* logic/csfm_new_clk_counter.sv */
`timescale 1ns/1ps
module csfm_new_clk_counter #(
	parameter int CYCLES = csfm_pkg::NEW_CLK_CYCLES
) (
	// system
	input wire logic i_mclk,
	input wire logic i_reset,
	// new source clock, sampled as a level
	input wire logic i_new_clk,
	// sequencer side
	csfm_cnt_if.counter cnt
);
	import csfm_pkg::*;

	localparam int CW = $clog2(CYCLES + 1);
	localparam logic [CW-1:0] LAST = CW'(CYCLES);

	logic sync1_reg;
	logic sync2_reg;
	logic prev_reg;
	logic [CW-1:0] count_reg;
	logic [CW-1:0] count_next;
	logic busy_reg;
	logic done_reg;
	wire rise = sync2_reg & ~prev_reg;

	// ----------------------------------------------------------------
	// resync; only the second stage feeds logic
	// ----------------------------------------------------------------
	always_ff @(posedge i_mclk or posedge i_reset) begin
		if (i_reset) begin
			sync1_reg <= 1'b0;
			sync2_reg <= 1'b0;
			prev_reg <= 1'b0;
		end else begin
			sync1_reg <= i_new_clk;
			sync2_reg <= sync1_reg;
			prev_reg <= sync2_reg;
		end
	end

	// ----------------------------------------------------------------
	// count rising edges of the new clock
	// ----------------------------------------------------------------
	assign count_next = cnt.start ? '0 :
		(busy_reg && rise) ? count_reg + CW'(1) : count_reg;

	always_ff @(posedge i_mclk or posedge i_reset) begin
		if (i_reset) begin
			count_reg <= '0;
			busy_reg <= 1'b0;
			done_reg <= 1'b0;
		end else begin
			count_reg <= count_next;
			busy_reg <= cnt.start | (busy_reg & (count_next != LAST));
			done_reg <= busy_reg & (count_next == LAST);
		end
	end

	assign cnt.done = done_reg;
	assign cnt.new_low = ~sync2_reg;

endmodule : csfm_new_clk_counter

/* logic/csfm_clock_switch.sv */
// Design decisions made here: the address map and register access over AXI4-Lite.
`timescale 1ns/1ps
// Behaviour
// - pll factor field is 9 bits, factor = value + 2, resets to 50
// - 6-bit two's-complement rc trim, 0.375 percent steps, zero nominal
// - switching and fail monitor off unless switching disable strap is 0
// - with switching off, active source follows initial-source strap only
// - with switching off, switch request does nothing and reads zero
// - request equal to active source clears request and aborts
// - starting a valid switch clears lock status and fail flag
// - start new oscillator, wait crystal timer or pll lock as needed
// - count 10 new-clock cycles before the switchover
// - switchover clears request and copies requested source to active
// - old oscillator stops; slow rc and secondary exempt when kept
// - sequencing never stalls the processor
// - primary submode is fixed by strap, never switched at runtime
// - with fail monitor on, slow rc runs always except in sleep
// - on failure raise trap and move system clock to fast rc
// - failure while on pll falls back to fast rc with pll
// - source fields use the 3-bit source encoding
// - fail flag reads one after a failure, software clears it
// - lock bit is one only when pll enabled and locked
module csfm_clock_switch (
	// system
	input wire logic i_mclk,
	input wire logic i_reset,
	// axi4-lite slave
	input wire logic i_awvalid,
	output logic o_awready,
	input wire logic [csfm_pkg::ADDR_W-1:0] i_awaddr,
	input wire logic i_wvalid,
	output logic o_wready,
	input wire logic [31:0] i_wdata,
	input wire logic [3:0] i_wstrb,
	output logic o_bvalid,
	input wire logic i_bready,
	output logic [1:0] o_bresp,
	input wire logic i_arvalid,
	output logic o_arready,
	input wire logic [csfm_pkg::ADDR_W-1:0] i_araddr,
	output logic o_rvalid,
	input wire logic i_rready,
	output logic [31:0] o_rdata,
	output logic [1:0] o_rresp,
	// configuration straps
	input wire logic i_switching_disable_cfg,
	input wire logic [2:0] i_initial_source_cfg,
	input wire logic [1:0] i_primary_submode_cfg,
	// oscillator status
	input wire logic i_crystal_startup_done,
	input wire logic i_pll_locked,
	input wire logic i_osc_fail,
	input wire logic i_new_clk,
	input wire logic i_cur_clk,
	input wire logic i_watchdog_enable,
	input wire logic i_sleep,
	// oscillator control
	output logic [2:0] o_sys_clk_sel,
	output logic [1:0] o_primary_submode,
	output logic o_fast_rc_en,
	output logic o_primary_en,
	output logic o_pll_en,
	output logic o_secondary_en,
	output logic o_slow_rc_en,
	output logic [csfm_pkg::PLL_W-1:0] o_pll_feedback_factor,
	output logic [csfm_pkg::TRIM_W-1:0] o_rc_trim_code,
	output logic o_clock_fail_trap
);
	import csfm_pkg::*;

	// ----------------------------------------------------------------
	// pin resync, two stages each
	// ----------------------------------------------------------------
	localparam int NS = 9;
	logic [NS-1:0] s1_reg;
	logic [NS-1:0] s2_reg;
	wire [NS-1:0] pins = {i_switching_disable_cfg, i_initial_source_cfg,
		i_crystal_startup_done, i_pll_locked, i_osc_fail, i_cur_clk,
		i_sleep};

	always_ff @(posedge i_mclk or posedge i_reset) begin
		if (i_reset) begin
			s1_reg <= '0;
			s2_reg <= '0;
		end else begin
			s1_reg <= pins;
			s2_reg <= s1_reg;
		end
	end

	wire sw_dis_s = s2_reg[8];
	wire [2:0] init_src_s = s2_reg[7:5];
	wire ost_s = s2_reg[4];
	wire lock_s = s2_reg[3];
	wire fail_s = s2_reg[2];
	wire cur_low = ~s2_reg[1];
	wire sleep_s = s2_reg[0];

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	csfm_state_e state_reg;
	csfm_state_e state_next;
	logic started_reg;
	logic [1:0] settle_reg;
	logic sw_enabled_reg;
	logic [2:0] active_reg;
	logic [2:0] req_reg;
	logic [2:0] sel_reg;
	logic swreq_reg;
	logic fail_flag_reg;
	logic lock_reg;
	logic sec_en_reg;
	logic fail_prev_reg;
	logic trap_reg;
	logic [PLL_W-1:0] pll_reg;
	logic [TRIM_W-1:0] trim_reg;
	logic [1:0] unlock_reg;
	csfm_cnt_if cnt ();

	// the switching disable strap is caught once, when the resync stages hold real pin values;
	// earlier the second stage still shows its reset zero
	always_ff @(posedge i_mclk or posedge i_reset) begin
		if (i_reset) begin
			settle_reg <= 2'h0;
			started_reg <= 1'b0;
			sw_enabled_reg <= 1'b0;
		end else if (!started_reg) begin
			settle_reg <= settle_reg + 2'h1;
			if (settle_reg == 2'h2) begin
				started_reg <= 1'b1;
				sw_enabled_reg <= ~sw_dis_s;
			end
		end
	end

	// ----------------------------------------------------------------
	// axi4-lite write path
	// ----------------------------------------------------------------
	logic aw_held_reg;
	logic w_held_reg;
	logic [ADDR_W-1:0] awaddr_reg;
	logic [31:0] wdata_reg;
	logic [3:0] wstrb_reg;
	logic bvalid_reg;
	logic [1:0] bresp_reg;

	assign o_awready = ~aw_held_reg;
	assign o_wready = ~w_held_reg;
	wire do_write = aw_held_reg & w_held_reg & ~bvalid_reg;
	// misaligned addresses stay unmapped and answer with an error
	wire [ADDR_W-1:0] wa = awaddr_reg;
	wire wr_ctrl = do_write && wa == OFS_OSC_CTRL;
	wire wr_pll = do_write && wa == OFS_PLL_MULT;
	wire wr_trim = do_write && wa == OFS_RC_TRIM;
	wire wr_key = do_write && wa == OFS_UNLOCK;
	wire wr_ok = wr_ctrl | wr_pll | wr_trim | wr_key;
	wire unlocked = unlock_reg == 2'h2;
	wire wr_hi = wr_ctrl & unlocked & wstrb_reg[1];
	wire wr_lo = wr_ctrl & unlocked & wstrb_reg[0];

	always_ff @(posedge i_mclk or posedge i_reset) begin
		if (i_reset) begin
			aw_held_reg <= 1'b0;
			w_held_reg <= 1'b0;
			awaddr_reg <= '0;
			wdata_reg <= '0;
			wstrb_reg <= '0;
			bvalid_reg <= 1'b0;
			bresp_reg <= RESP_OKAY;
		end else begin
			if (i_awvalid && !aw_held_reg) begin
				aw_held_reg <= 1'b1;
				awaddr_reg <= i_awaddr;
			end else if (do_write) begin
				aw_held_reg <= 1'b0;
			end
			if (i_wvalid && !w_held_reg) begin
				w_held_reg <= 1'b1;
				wdata_reg <= i_wdata;
				wstrb_reg <= i_wstrb;
			end else if (do_write) begin
				w_held_reg <= 1'b0;
			end
			if (do_write) begin
				bvalid_reg <= 1'b1;
				bresp_reg <= wr_ok ? RESP_OKAY : RESP_SLVERR;
			end else if (i_bready) begin
				bvalid_reg <= 1'b0;
			end
		end
	end

	assign o_bvalid = bvalid_reg;
	assign o_bresp = bresp_reg;

	// ----------------------------------------------------------------
	// unlock: key1 then key2, good for the very next write only
	// ----------------------------------------------------------------
	wire [15:0] key = wdata_reg[15:0];

	always_ff @(posedge i_mclk or posedge i_reset) begin
		if (i_reset) begin
			unlock_reg <= 2'h0;
		end else if (do_write) begin
			if (wr_key && key == UNLOCK_KEY1) begin
				unlock_reg <= 2'h1;
			end else if (wr_key && key == UNLOCK_KEY2 && unlock_reg == 2'h1) begin
				unlock_reg <= 2'h2;
			end else begin
				unlock_reg <= 2'h0;
			end
		end
	end

	always_ff @(posedge i_mclk or posedge i_reset) begin
		if (i_reset) begin
			pll_reg <= RST_PLL_MULT;
			trim_reg <= RST_RC_TRIM;
		end else begin
			if (wr_pll && wstrb_reg[0]) begin
				pll_reg[7:0] <= wdata_reg[7:0];
			end
			if (wr_pll && wstrb_reg[1]) begin
				pll_reg[8] <= wdata_reg[8];
			end
			if (wr_trim && wstrb_reg[0]) begin
				trim_reg <= wdata_reg[TRIM_W-1:0];
			end
		end
	end

	// ----------------------------------------------------------------
	// switch sequencer; runs beside the cpu, never holds the bus
	// ----------------------------------------------------------------
	wire fail_evt = sw_enabled_reg & fail_s & ~fail_prev_reg;
	wire same_src = req_reg == active_reg;
	wire ready = (!uses_pri(req_reg) || ost_s) &&
		(!uses_pll(req_reg) || lock_s);
	wire valid_start = state_reg == ST_CHECK && !same_src;
	wire swap_now = state_reg == ST_SWAP && cnt.new_low && cur_low;
	wire [2:0] fallback = uses_pll(active_reg) ? SRC_FRC_PLL : SRC_FRC;
	wire busy = state_reg != ST_IDLE;

	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			ST_IDLE: if (swreq_reg) state_next = ST_CHECK;
			ST_CHECK: state_next = same_src ? ST_IDLE : ST_WAIT;
			ST_WAIT: if (ready) state_next = ST_COUNT;
			ST_COUNT: if (cnt.done) state_next = ST_SWAP;
			ST_SWAP: if (swap_now) state_next = ST_IDLE;
			default: state_next = ST_IDLE;
		endcase
		if (fail_evt) begin
			state_next = ST_IDLE;
		end
	end

	assign cnt.start = state_reg == ST_WAIT && ready;

	csfm_new_clk_counter #(
		.CYCLES(NEW_CLK_CYCLES)
	) u_counter (
		.i_mclk(i_mclk),
		.i_reset(i_reset),
		.i_new_clk(i_new_clk),
		.cnt(cnt)
	);

	always_ff @(posedge i_mclk or posedge i_reset) begin
		if (i_reset) begin
			state_reg <= ST_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	// ----------------------------------------------------------------
	// oscillator control fields
	// ----------------------------------------------------------------
	wire swreq_clr = (state_reg == ST_CHECK && same_src) || swap_now ||
		fail_evt;

	always_ff @(posedge i_mclk or posedge i_reset) begin
		if (i_reset) begin
			active_reg <= SRC_FRC;
			req_reg <= SRC_FRC;
			sel_reg <= SRC_FRC;
			swreq_reg <= 1'b0;
			sec_en_reg <= 1'b0;
			fail_flag_reg <= 1'b0;
			fail_prev_reg <= 1'b0;
			trap_reg <= 1'b0;
			lock_reg <= 1'b0;
		end else begin
			fail_prev_reg <= fail_s;
			trap_reg <= fail_evt;
			lock_reg <= valid_start ? 1'b0 : (o_pll_en & lock_s);
			if (!started_reg || !sw_enabled_reg) begin
				active_reg <= init_src_s;
				sel_reg <= init_src_s;
				if (!started_reg) begin
					req_reg <= init_src_s;
				end
			end else if (fail_evt) begin
				active_reg <= fallback;
				sel_reg <= fallback;
			end else if (swap_now) begin
				active_reg <= req_reg;
				sel_reg <= req_reg;
			end
			if (wr_hi && !busy) begin
				req_reg <= wdata_reg[POS_REQ+:3];
			end
			if (swreq_clr || !sw_enabled_reg) begin
				swreq_reg <= 1'b0;
			end else if (wr_lo && wdata_reg[POS_SWREQ]) begin
				swreq_reg <= 1'b1;
			end
			if (wr_lo) begin
				sec_en_reg <= wdata_reg[POS_SEC_EN];
			end
			// a failure in the clearing cycle keeps the flag set
			if (fail_evt) begin
				fail_flag_reg <= 1'b1;
			end else if (valid_start || (wr_lo && !wdata_reg[POS_FAIL])) begin
				fail_flag_reg <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// oscillator enables; old source drops once busy falls
	// ----------------------------------------------------------------
	wire [2:0] tgt = busy ? req_reg : active_reg;
	assign o_fast_rc_en = uses_frc(active_reg) | uses_frc(tgt);
	assign o_primary_en = uses_pri(active_reg) | uses_pri(tgt);
	assign o_pll_en = uses_pll(active_reg) | uses_pll(tgt);
	assign o_secondary_en = active_reg == SRC_SEC || tgt == SRC_SEC ||
		sec_en_reg;
	assign o_slow_rc_en = active_reg == SRC_SLOW || tgt == SRC_SLOW ||
		i_watchdog_enable || (sw_enabled_reg && !sleep_s);
	assign o_sys_clk_sel = sel_reg;
	assign o_primary_submode = i_primary_submode_cfg;
	assign o_pll_feedback_factor = pll_reg;
	assign o_rc_trim_code = trim_reg;
	assign o_clock_fail_trap = trap_reg;

	// ----------------------------------------------------------------
	// axi4-lite read path
	// ----------------------------------------------------------------
	logic rvalid_reg;
	logic [31:0] rdata_reg;
	logic [1:0] rresp_reg;
	wire [ADDR_W-1:0] ra = i_araddr;
	wire [31:0] ctrl_word = {17'h0, active_reg, 1'b0, req_reg, 2'h0,
		lock_reg, 1'b0, fail_flag_reg, 1'b0, sec_en_reg, swreq_reg};
	wire rd_hit = ra == OFS_OSC_CTRL || ra == OFS_PLL_MULT ||
		ra == OFS_RC_TRIM || ra == OFS_UNLOCK;
	wire [31:0] rd_mux = (ra == OFS_OSC_CTRL) ? ctrl_word :
		(ra == OFS_PLL_MULT) ? {23'h0, pll_reg} :
		(ra == OFS_RC_TRIM) ? {26'h0, trim_reg} : 32'h0;

	assign o_arready = ~rvalid_reg;

	always_ff @(posedge i_mclk or posedge i_reset) begin
		if (i_reset) begin
			rvalid_reg <= 1'b0;
			rdata_reg <= 32'h0;
			rresp_reg <= RESP_OKAY;
		end else if (i_arvalid && !rvalid_reg) begin
			rvalid_reg <= 1'b1;
			rdata_reg <= rd_mux;
			rresp_reg <= rd_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (i_rready) begin
			rvalid_reg <= 1'b0;
		end
	end

	assign o_rvalid = rvalid_reg;
	assign o_rdata = rdata_reg;
	assign o_rresp = rresp_reg;

endmodule : csfm_clock_switch

/* bench/csfm_clock_switch_properties.sv */
`timescale 1ns/1ps
module csfm_clock_switch_properties (
	// system
	input wire logic i_mclk,
	input wire logic i_reset,
	// bus
	input wire logic i_wvalid,
	input wire logic i_arvalid,
	input wire logic o_arready,
	input wire logic o_rvalid,
	// straps and status
	input wire logic i_switching_disable_cfg,
	input wire logic [2:0] i_initial_source_cfg,
	input wire logic [1:0] i_primary_submode_cfg,
	input wire logic i_watchdog_enable,
	input wire logic i_sleep,
	// oscillator control
	input wire logic [2:0] o_sys_clk_sel,
	input wire logic [1:0] o_primary_submode,
	input wire logic o_fast_rc_en,
	input wire logic o_primary_en,
	input wire logic o_pll_en,
	input wire logic o_slow_rc_en,
	input wire logic [csfm_pkg::PLL_W-1:0] o_pll_feedback_factor,
	input wire logic o_clock_fail_trap
);
	import csfm_pkg::*;
	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (i_reset);

	trap_one_pulse_a: assert property (
		o_clock_fail_trap |=> !o_clock_fail_trap)
		else $error("trap pulse longer than one cycle");
	trap_when_off_a: assert property (
		i_switching_disable_cfg [*4] |-> !o_clock_fail_trap)
		else $error("trap raised with monitor disabled");
	trap_fallback_a: assert property (
		$rose(o_clock_fail_trap) |-> ##[0:1] (o_sys_clk_sel inside {3'h0, 3'h1}))
		else $error("failure did not fall back to fast rc");
	pll_by_write_a: assert property (
		$changed(o_pll_feedback_factor) |-> $past(i_wvalid) || $past(i_wvalid, 2))
		else $error("pll factor changed without a write");
	read_answer_a: assert property (
		i_arvalid && o_arready |=> o_rvalid)
		else $error("read not answered next cycle");
	strap_source_a: assert property (
		i_switching_disable_cfg [*6] |-> o_sys_clk_sel == i_initial_source_cfg)
		else $error("select differs from strap with switching off");
	submode_fixed_a: assert property (
		o_primary_submode == i_primary_submode_cfg)
		else $error("primary submode not from strap");
	pri_pll_on_a: assert property (
		o_sys_clk_sel == 3'h3 |-> o_primary_en && o_pll_en)
		else $error("primary with pll selected but not running");
	frc_on_a: assert property (
		o_sys_clk_sel inside {3'h0, 3'h1, 3'h6, 3'h7} |-> o_fast_rc_en)
		else $error("fast rc selected but stopped");
	slow_wdt_a: assert property (
		i_watchdog_enable |-> o_slow_rc_en)
		else $error("slow rc stopped while watchdog on");
	slow_monitor_a: assert property (
		(!i_switching_disable_cfg && !i_sleep) [*4] |-> o_slow_rc_en)
		else $error("slow rc stopped while monitor on");
endmodule : csfm_clock_switch_properties

bind csfm_clock_switch csfm_clock_switch_properties u_props (
	.i_mclk(i_mclk), .i_reset(i_reset), .i_wvalid(i_wvalid),
	.i_arvalid(i_arvalid), .o_arready(o_arready), .o_rvalid(o_rvalid),
	.i_switching_disable_cfg(i_switching_disable_cfg),
	.i_initial_source_cfg(i_initial_source_cfg),
	.i_primary_submode_cfg(i_primary_submode_cfg),
	.i_watchdog_enable(i_watchdog_enable), .i_sleep(i_sleep),
	.o_sys_clk_sel(o_sys_clk_sel), .o_primary_submode(o_primary_submode),
	.o_fast_rc_en(o_fast_rc_en), .o_primary_en(o_primary_en),
	.o_pll_en(o_pll_en), .o_slow_rc_en(o_slow_rc_en),
	.o_pll_feedback_factor(o_pll_feedback_factor),
	.o_clock_fail_trap(o_clock_fail_trap)
);

/* bench/csfm_clock_switch_test.sv */
`timescale 1ns/1ps
module csfm_clock_switch_test;
	import csfm_pkg::*;
	// ----------------------------------------------------------------
	// signals
	// ----------------------------------------------------------------
	logic i_mclk = 0, i_reset = 1, i_awvalid = 0, i_wvalid = 0, i_bready = 0;
	logic i_arvalid = 0, i_rready = 0, i_sleep = 0, i_watchdog_enable = 0;
	logic i_crystal_startup_done = 0, i_pll_locked = 0, i_osc_fail = 0;
	logic i_switching_disable_cfg = 0, i_new_clk = 0, i_cur_clk = 0, run = 1;
	logic [1:0] i_primary_submode_cfg = 2'h1, resp, o_bresp, o_rresp;
	logic [2:0] i_initial_source_cfg = 3'h0, ph = 3'h0, o_sys_clk_sel;
	logic [3:0] i_awaddr = 4'h0, i_araddr = 4'h0, i_wstrb = 4'h0;
	logic [31:0] i_wdata = 32'h0, rdat, o_rdata;
	logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_pll_en;
	logic o_fast_rc_en, o_primary_en, o_secondary_en, o_slow_rc_en;
	logic o_clock_fail_trap;
	logic [1:0] o_primary_submode;
	logic [8:0] o_pll_feedback_factor, pv;
	logic [5:0] o_rc_trim_code, tv;
	int num_errors = 0, samples_checked = 0, traps = 0;

	csfm_clock_switch DUT (
		.i_mclk(i_mclk), .i_reset(i_reset), .i_awvalid(i_awvalid),
		.o_awready(o_awready), .i_awaddr(i_awaddr), .i_wvalid(i_wvalid),
		.o_wready(o_wready), .i_wdata(i_wdata), .i_wstrb(i_wstrb),
		.o_bvalid(o_bvalid), .i_bready(i_bready), .o_bresp(o_bresp),
		.i_arvalid(i_arvalid), .o_arready(o_arready), .i_araddr(i_araddr),
		.o_rvalid(o_rvalid), .i_rready(i_rready), .o_rdata(o_rdata),
		.o_rresp(o_rresp), .i_switching_disable_cfg(i_switching_disable_cfg),
		.i_initial_source_cfg(i_initial_source_cfg),
		.i_primary_submode_cfg(i_primary_submode_cfg),
		.i_crystal_startup_done(i_crystal_startup_done),
		.i_pll_locked(i_pll_locked), .i_osc_fail(i_osc_fail),
		.i_new_clk(i_new_clk), .i_cur_clk(i_cur_clk),
		.i_watchdog_enable(i_watchdog_enable), .i_sleep(i_sleep),
		.o_sys_clk_sel(o_sys_clk_sel), .o_primary_submode(o_primary_submode),
		.o_fast_rc_en(o_fast_rc_en), .o_primary_en(o_primary_en),
		.o_pll_en(o_pll_en), .o_secondary_en(o_secondary_en),
		.o_slow_rc_en(o_slow_rc_en),
		.o_pll_feedback_factor(o_pll_feedback_factor),
		.o_rc_trim_code(o_rc_trim_code), .o_clock_fail_trap(o_clock_fail_trap)
	);

	always #25 i_mclk = ~i_mclk;
	// new clock can be stopped to hold a switch in its count
	always @(posedge i_mclk) begin
		ph <= ph + 3'h1;
		i_new_clk <= run & ph[1];
		i_cur_clk <= ph[2];
	end
	always @(negedge i_mclk) traps += int'(o_clock_fail_trap === 1'b1);
	// ----------------------------------------------------------------
	// tasks
	// ----------------------------------------------------------------
	task automatic chk(input string what, input logic [31:0] exp, got);
		samples_checked++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected %s: expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic wr(input logic [3:0] a, input logic [31:0] d,
		input logic [3:0] s);
		logic ta, tw, tb;
		int n;
		n = 0;
		tb = 0;
		@(posedge i_mclk);
		i_awvalid <= 1'b1;
		i_wvalid <= 1'b1;
		i_awaddr <= a;
		i_wdata <= d;
		i_wstrb <= s;
		i_bready <= 1'b1;
		while (!tb && n < 100) begin
			@(negedge i_mclk);
			ta = i_awvalid & o_awready;
			tw = i_wvalid & o_wready;
			tb = o_bvalid;
			resp = o_bresp;
			@(posedge i_mclk);
			if (ta) i_awvalid <= 1'b0;
			if (tw) i_wvalid <= 1'b0;
			n++;
		end
		i_bready <= 1'b0;
		if (!tb) num_errors++;
	endtask : wr

	task automatic rd(input logic [3:0] a);
		logic tr, tv;
		int n;
		n = 0;
		tv = 0;
		@(posedge i_mclk);
		i_arvalid <= 1'b1;
		i_araddr <= a;
		i_rready <= 1'b1;
		while (!tv && n < 100) begin
			@(negedge i_mclk);
			tr = i_arvalid & o_arready;
			tv = o_rvalid;
			rdat = o_rdata;
			resp = o_rresp;
			@(posedge i_mclk);
			if (tr) i_arvalid <= 1'b0;
			n++;
		end
		i_rready <= 1'b0;
		if (!tv) num_errors++;
	endtask : rd

	task automatic unlock;
		wr(OFS_UNLOCK, {16'h0, UNLOCK_KEY1}, 4'h3);
		wr(OFS_UNLOCK, {16'h0, UNLOCK_KEY2}, 4'h3);
	endtask : unlock

	// low byte keeps the fail flag bit at one so a write never clears it
	task automatic req(input logic [2:0] s);
		unlock;
		wr(OFS_OSC_CTRL, {21'h0, s, 8'h0}, 4'h2);
		unlock;
		wr(OFS_OSC_CTRL, 32'h9, 4'h1);
	endtask : req

	task automatic settle;
		int n;
		n = 0;
		rd(OFS_OSC_CTRL);
		while (rdat[0] !== 1'b0 && n < 80) begin
			rd(OFS_OSC_CTRL);
			n++;
		end
		if (rdat[0] !== 1'b0) num_errors++;
	endtask : settle

	task automatic rst(input logic d, input logic [2:0] s);
		i_reset <= 1'b1;
		i_switching_disable_cfg <= d;
		i_initial_source_cfg <= s;
		repeat (20) @(posedge i_mclk);
		i_reset <= 1'b0;
		repeat (5) @(posedge i_mclk);
	endtask : rst

	task automatic summarize;
		if (num_errors == 0 && samples_checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : summarize
	// ----------------------------------------------------------------
	// tests
	// ----------------------------------------------------------------
	initial begin
		repeat (20000) @(posedge i_mclk);
		num_errors++;
		summarize;
	end

	initial begin
		rst(1'b0, SRC_FRC);
		rd(OFS_PLL_MULT);
		chk("pll reset", 32'h30, rdat);
		rd(OFS_RC_TRIM);
		chk("trim reset", 32'h0, rdat);
		for (int i = 0; i < 2; i++) begin
			pv = i ? 9'h1FF : 9'h000;
			tv = i ? 6'h20 : 6'h1F;
			wr(OFS_PLL_MULT, {23'h7FFFFF, pv}, 4'hF);
			wr(OFS_RC_TRIM, {26'h3FFFFFF, tv}, 4'hF);
			rd(OFS_PLL_MULT);
			chk("pll field", {23'h0, pv}, rdat);
			chk("pll out", {23'h0, pv}, {23'h0, o_pll_feedback_factor});
			rd(OFS_RC_TRIM);
			chk("trim field", {26'h0, tv}, rdat);
			chk("trim out", {26'h0, tv}, {26'h0, o_rc_trim_code});
		end
		rd(4'h2);
		chk("unmapped resp", {30'h0, RESP_SLVERR}, {30'h0, resp});
		wr(4'h6, 32'h0, 4'hF);
		chk("unmapped wr", {30'h0, RESP_SLVERR}, {30'h0, resp});
		wr(OFS_OSC_CTRL, 32'h0300, 4'h2);
		chk("ignored resp", {30'h0, RESP_OKAY}, {30'h0, resp});
		rd(OFS_OSC_CTRL);
		chk("no unlock", 32'h0, {16'h0, rdat[15:0]} & 32'h7701);
		req(SRC_PRI);
		repeat (30) @(posedge i_mclk);
		rd(OFS_OSC_CTRL);
		chk("xtal wait", 32'h1, {31'h0, rdat[0]});
		chk("primary on", 32'h1, {31'h0, o_primary_en});
		i_crystal_startup_done <= 1'b1;
		settle;
		chk("ctrl pri", 32'h2200, {16'h0, rdat[15:0]} & 32'h7701);
		chk("sel pri", 32'h2, {29'h0, o_sys_clk_sel});
		chk("frc off", 32'h0, {31'h0, o_fast_rc_en});
		req(SRC_PRI);
		rd(OFS_OSC_CTRL);
		chk("redundant", 32'h2000, {16'h0, rdat[15:0]} & 32'h7001);
		run <= 1'b0;
		req(SRC_FRC);
		repeat (20) @(posedge i_mclk);
		run <= 1'b1;
		repeat (36) @(posedge i_mclk);
		chk("early swap", 32'h2, {29'h0, o_sys_clk_sel});
		settle;
		chk("sel frc", 32'h0, {29'h0, o_sys_clk_sel});
		i_pll_locked <= 1'b1;
		req(SRC_PRI_PLL);
		settle;
		chk("ctrl pll", 32'h3320, {16'h0, rdat[15:0]} & 32'h7721);
		i_osc_fail <= 1'b1;
		repeat (6) @(posedge i_mclk);
		chk("pll fallback", 32'h1, {29'h0, o_sys_clk_sel});
		chk("trap count", 32'h1, traps);
		rd(OFS_OSC_CTRL);
		chk("fail flag", 32'h1008, {16'h0, rdat[15:0]} & 32'h7009);
		i_osc_fail <= 1'b0;
		req(SRC_PRI);
		settle;
		chk("start clears", 32'h2000, {16'h0, rdat[15:0]} & 32'h7029);
		i_osc_fail <= 1'b1;
		repeat (6) @(posedge i_mclk);
		chk("frc fallback", 32'h0, {29'h0, o_sys_clk_sel});
		i_osc_fail <= 1'b0;
		unlock;
		wr(OFS_OSC_CTRL, 32'h2, 4'h1);
		rd(OFS_OSC_CTRL);
		chk("flag clear", 32'h0, {16'h0, rdat[15:0]} & 32'h7009);
		chk("sec kept", 32'h1, {31'h0, o_secondary_en});
		i_watchdog_enable <= 1'b1;
		i_sleep <= 1'b1;
		rst(1'b1, SRC_SLOW);
		req(SRC_FRC);
		rd(OFS_OSC_CTRL);
		chk("off ctrl", 32'h5000, {16'h0, rdat[15:0]} & 32'h7009);
		chk("off sel", 32'h5, {29'h0, o_sys_clk_sel});
		i_osc_fail <= 1'b1;
		repeat (8) @(posedge i_mclk);
		chk("off trap", 32'h2, traps);
		chk("off slow", 32'h1, {31'h0, o_slow_rc_en});
		summarize;
	end
endmodule : csfm_clock_switch_test
